// ---- verilog/contact_input_config_status.sv ----
// Configuration/status register, indicator drive and chatter timing of the contact input module
`timescale 1ns/1ps
module contact_input_config_status #(
    parameter int CHAT_TICK_CYCLES = contact_input_pkg::CHAT_TICK_CYC,
    parameter int COMM_TIMEOUT_CYCLES = contact_input_pkg::COMM_TIMEOUT_CYC,
    parameter int COMM_LED_CYCLES = contact_input_pkg::COMM_LED_CYC
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [3:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_read_block,
    input wire logic fuse_blown_in,
    input wire logic aux_fail_in,
    input wire logic gnd_fault_in,
    input wire logic clk_sync_in,
    input wire logic [15:0] contact_closed_in,
    output logic attention,
    output contact_input_pkg::led_drive_s leds,
    output contact_input_pkg::module_ctrl_s ctrl
);
    logic [15:0] cfg_ff;
    logic [15:0] nxt_cfg;
    logic [15:0] stat;
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic [15:0] ch_meta_ff;
    logic [15:0] ch_sync_ff;
    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    logic [31:0] wd_cnt_ff;
    logic wd_timeout_ff;
    logic [31:0] led_cnt_ff;
    logic comms_ff;
    logic access;

    // Field signals arrive asynchronously
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_ff <= 4'h0;
            sync_ff <= 4'h0;
            ch_meta_ff <= 16'h0000;
            ch_sync_ff <= 16'h0000;
        end
        else
        begin
            meta_ff <= {clk_sync_in, gnd_fault_in, aux_fail_in, fuse_blown_in};
            sync_ff <= meta_ff;
            ch_meta_ff <= contact_closed_in;
            ch_sync_ff <= ch_meta_ff;
        end
    end

    wire fuse_s = sync_ff[0];
    wire aux_s = sync_ff[1];
    wire gnd_s = sync_ff[2];
    wire csync_s = sync_ff[3];

    assign access = bus_sel && (bus_addr == contact_input_pkg::CFG_STAT_ADDR);

    // Unused bits are dropped so stray writes cannot reach the echo
    always_comb
    begin
        nxt_cfg = cfg_ff;
        if (access && bus_wr)
            nxt_cfg = bus_wdata & contact_input_pkg::CFG_USED_MASK; // [R01] [R13]
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            cfg_ff <= contact_input_pkg::CFG_RESET; // [R19]
        else
            cfg_ff <= nxt_cfg;
    end

    always_comb
    begin
        stat = 16'h0000;
        stat[contact_input_pkg::B_CONFIGURE] = cfg_ff[contact_input_pkg::B_CONFIGURE]; // [R03]
        stat[contact_input_pkg::B_FORCE_ERR] = cfg_ff[contact_input_pkg::B_FORCE_ERR]; // [R05]
        stat[contact_input_pkg::B_FUSE_EN] = cfg_ff[contact_input_pkg::B_FUSE_EN]; // [R06] [R12]
        stat[contact_input_pkg::B_FUSE_BLOWN] = cfg_ff[contact_input_pkg::B_FUSE_EN] & fuse_s; // [R06]
        stat[contact_input_pkg::B_AUX_EN] = cfg_ff[contact_input_pkg::B_AUX_EN]; // [R07] [R12]
        stat[contact_input_pkg::B_AUX_FAIL] = cfg_ff[contact_input_pkg::B_AUX_EN] & aux_s; // [R08]
        stat[contact_input_pkg::B_GND_EN] = cfg_ff[contact_input_pkg::B_GND_EN]; // [R09] [R12]
        stat[contact_input_pkg::B_GND_FAULT] = cfg_ff[contact_input_pkg::B_AUX_EN] & gnd_s; // [R09]
        stat[contact_input_pkg::B_CHAT_OFF] = cfg_ff[contact_input_pkg::B_CHAT_OFF]; // [R12]
        stat[contact_input_pkg::B_CHAT_UNFRZ] = cfg_ff[contact_input_pkg::B_CHAT_UNFRZ]; // [R12]
        stat[contact_input_pkg::B_CLK_SYNC] = csync_s;
    end

    // Read data registered; status always readable
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            bus_rdata <= 16'h0000;
        else if (bus_sel && bus_rd)
            bus_rdata <= access ? stat : contact_input_pkg::STAT_RESTRICTED; // [R01]
    end

    // Other registers of the module must refuse reads while error is forced
    assign bus_read_block = cfg_ff[contact_input_pkg::B_FORCE_ERR]; // [R04]

    // 100 ms chatter decrement tick, one-cycle enable
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
        end
        else if (!cfg_ff[contact_input_pkg::B_CONFIGURE]
            || cfg_ff[contact_input_pkg::B_CHAT_UNFRZ]) // [R11]
        begin
            tick_cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
        end
        else if (tick_cnt_ff == 32'(CHAT_TICK_CYCLES - 1))
        begin
            tick_cnt_ff <= 32'h0;
            tick_ff <= 1'b1; // [R11]
        end
        else
        begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end

    // Communication watchdog; armed only once configured
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wd_cnt_ff <= 32'h0;
            wd_timeout_ff <= 1'b0;
        end
        else if (bus_sel || !cfg_ff[contact_input_pkg::B_CONFIGURE])
        begin
            wd_cnt_ff <= 32'h0;
            wd_timeout_ff <= 1'b0;
        end
        else if (wd_cnt_ff == 32'(COMM_TIMEOUT_CYCLES - 1))
            wd_timeout_ff <= 1'b1; // [R20]
        else
            wd_cnt_ff <= wd_cnt_ff + 32'h1;
    end

    // Communications LED stretched so brief accesses are visible
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            led_cnt_ff <= 32'h0;
            comms_ff <= 1'b0;
        end
        else if (bus_sel)
        begin
            led_cnt_ff <= 32'(COMM_LED_CYCLES - 1);
            comms_ff <= 1'b1; // [R17]
        end
        else if (led_cnt_ff != 32'h0)
            led_cnt_ff <= led_cnt_ff - 32'h1;
        else
            comms_ff <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            leds <= '0;
        else
        begin
            leds.ext_fault <= cfg_ff[contact_input_pkg::B_AUX_EN] & gnd_s; // [R15]
            leds.int_fault <= cfg_ff[contact_input_pkg::B_FORCE_ERR] // [R04]
                | (cfg_ff[contact_input_pkg::B_AUX_EN] & aux_s) // [R16]
                | wd_timeout_ff; // [R20]
            leds.comms_ok <= comms_ff; // [R17]
            leds.channel_state_leds <= ch_sync_ff; // [R18]
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl <= '0;
            attention <= 1'b0;
        end
        else
        begin
            ctrl.module_enable <= cfg_ff[contact_input_pkg::B_CONFIGURE]; // [R02]
            ctrl.fuse_sense_en <= cfg_ff[contact_input_pkg::B_FUSE_EN]; // [R06]
            ctrl.aux_sense_en <= cfg_ff[contact_input_pkg::B_AUX_EN]; // [R07]
            ctrl.gnd_attn_en <= cfg_ff[contact_input_pkg::B_GND_EN]; // [R09]
            ctrl.chatter_disable <= cfg_ff[contact_input_pkg::B_CHAT_OFF]; // [R10]
            ctrl.chatter_reset_on_unfreeze <= cfg_ff[contact_input_pkg::B_CHAT_UNFRZ]; // [R11]
            ctrl.chatter_tick <= tick_ff & ~cfg_ff[contact_input_pkg::B_CHAT_OFF]; // [R10]
            attention <= cfg_ff[contact_input_pkg::B_CONFIGURE] & ( // [R02]
                (cfg_ff[contact_input_pkg::B_FUSE_EN] & fuse_s)
                | (cfg_ff[contact_input_pkg::B_AUX_EN] & aux_s)
                | (cfg_ff[contact_input_pkg::B_GND_EN] & cfg_ff[contact_input_pkg::B_AUX_EN]
                   & gnd_s));
        end
    end

    property p_write_loads;
        @(posedge ref_clk) disable iff (!reset_n)
        (access && bus_wr) |=> cfg_ff == ($past(bus_wdata) & contact_input_pkg::CFG_USED_MASK);
    endproperty
    a_write_loads: assert property (p_write_loads) else $error("config write lost"); // [R01]

    property p_idle_unconfigured;
        @(posedge ref_clk) disable iff (!reset_n)
        !cfg_ff[contact_input_pkg::B_CONFIGURE] |=> !ctrl.module_enable && !attention;
    endproperty
    a_idle_unconfigured: assert property (p_idle_unconfigured) else $error("active unconfigured"); // [R02]

    sequence s_stat_read;
        access && bus_rd ##1 1'b1;
    endsequence
    property p_status_read;
        @(posedge ref_clk) disable iff (!reset_n)
        (access && bus_rd) |=> bus_rdata[1:0] == $past(cfg_ff[1:0]);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bits 0/1 wrong"); // [R03] [R05]

    property p_echo;
        @(posedge ref_clk) disable iff (!reset_n)
        s_stat_read |-> (bus_rdata & 16'h3540) == ($past(cfg_ff) & 16'h3540);
    endproperty
    a_echo: assert property (p_echo) else $error("echo bits wrong"); // [R12]

    property p_force_led;
        @(posedge ref_clk) disable iff (!reset_n)
        cfg_ff[contact_input_pkg::B_FORCE_ERR] |-> bus_read_block ##1 leds.int_fault;
    endproperty
    a_force_led: assert property (p_force_led) else $error("forced error not shown"); // [R04]

    property p_aux_led;
        @(posedge ref_clk) disable iff (!reset_n)
        (!cfg_ff[8] && !cfg_ff[1] && !wd_timeout_ff) |=> !leds.int_fault;
    endproperty
    a_aux_led: assert property (p_aux_led) else $error("internal fault unexpected"); // [R16]

    property p_gnd_led;
        @(posedge ref_clk) disable iff (!reset_n)
        (cfg_ff[8] && gnd_s) |=> leds.ext_fault;
    endproperty
    a_gnd_led: assert property (p_gnd_led) else $error("ground fault not lit"); // [R15]

    property p_channels;
        @(posedge ref_clk) disable iff (!reset_n)
        1'b1 |=> leds.channel_state_leds == $past(ch_sync_ff);
    endproperty
    a_channels: assert property (p_channels) else $error("channel led mismatch"); // [R18]

    property p_comms;
        @(posedge ref_clk) disable iff (!reset_n)
        bus_sel |=> ##1 leds.comms_ok;
    endproperty
    a_comms: assert property (p_comms) else $error("comms led not lit"); // [R17]

    property p_chat_off;
        @(posedge ref_clk) disable iff (!reset_n)
        cfg_ff[12] |=> !ctrl.chatter_tick;
    endproperty
    a_chat_off: assert property (p_chat_off) else $error("tick while chatter off"); // [R10]

    property p_no_tick_unfreeze;
        @(posedge ref_clk) disable iff (!reset_n)
        cfg_ff[13] |=> !tick_ff;
    endproperty
    a_no_tick_unfreeze: assert property (p_no_tick_unfreeze) else $error("tick in unfreeze mode"); // [R11]

    // Fault flags reach status only through their enables
    property p_fault_status;
        @(posedge ref_clk) disable iff (!reset_n)
        (access && bus_rd) |=> bus_rdata[contact_input_pkg::B_FUSE_BLOWN]
            == $past(cfg_ff[contact_input_pkg::B_FUSE_EN] && fuse_s)
            && bus_rdata[contact_input_pkg::B_AUX_FAIL]
            == $past(cfg_ff[contact_input_pkg::B_AUX_EN] && aux_s);
    endproperty
    a_fault_status: assert property (p_fault_status) else $error("fault status wrong"); // [R06] [R08]

    property p_gnd_status;
        @(posedge ref_clk) disable iff (!reset_n)
        (access && bus_rd) |=> bus_rdata[contact_input_pkg::B_GND_FAULT]
            == $past(cfg_ff[contact_input_pkg::B_AUX_EN] && gnd_s);
    endproperty
    a_gnd_status: assert property (p_gnd_status) else $error("ground status wrong"); // [R09]

    property p_aux_int;
        @(posedge ref_clk) disable iff (!reset_n)
        (cfg_ff[contact_input_pkg::B_AUX_EN] && aux_s) |=> leds.int_fault;
    endproperty
    a_aux_int: assert property (p_aux_int) else $error("aux failure not lit"); // [R16]

    property p_wd_led;
        @(posedge ref_clk) disable iff (!reset_n)
        wd_timeout_ff |=> leds.int_fault;
    endproperty
    a_wd_led: assert property (p_wd_led) else $error("watchdog timeout not lit"); // [R20]
endmodule : contact_input_config_status

// ---- verilog/contact_input_pkg.sv ----
// Constants and carrier types of the contact input configuration and status register
// Function
// [R01] One word address: writes load configuration, reads return status.
// [R02] Module does nothing until configuration bit 0 is written to one; fault LEDs, status fault flags and ctrl sense enables act without it.
// [R03] Status bit 0 reads one once configured, zero otherwise.
// [R04] Config bit 1 lights internal fault and limits reads to status.
// [R05] Status bit 1 reads one while internal error is forced.
// [R06] Config bit 6 enables blown fuse; status 6 echoes, status 7 reports.
// [R07] Config bit 8 enables aux failure, attention, ground detection; status echoes.
// [R08] Status bit 9 reports auxiliary contact supply failure.
// [R09] Config bit 10 enables ground-fault attention; status 10 echoes, 11 reports.
// [R10] Config bit 12 disables chatter control; default keeps it active.
// [R11] Config bit 13 resets chatter counters on unfreeze, else 100 ms decrement.
// [R12] Status echoes configuration bits 6, 8, 10, 12 and 13 in place.
// [R13] Controller writes zero to unused configuration bits.
// [R14] Controller clears bit 6, sets bit 8, sets bit 10 as needed.
// [R15] External fault indicator lit whenever a ground fault is detected.
// [R16] Internal fault indicator lit on aux supply failure only with bit 8.
// [R17] Communications indicator lit while controller is communicating.
// [R18] Sixteen channel indicators, each lit while its contact is closed.
// [R19] Reset clears all configuration bits.
// [R20] Internal fault indicator also lit on communication watchdog timeout.
package contact_input_pkg;
    localparam logic [3:0] CFG_STAT_ADDR = 4'hd;
    localparam int DATA_W = 16;
    localparam int CHANNELS = 16;
    localparam int B_CONFIGURE = 0;
    localparam int B_FORCE_ERR = 1;
    localparam int B_FUSE_EN = 6;
    localparam int B_FUSE_BLOWN = 7;
    localparam int B_AUX_EN = 8;
    localparam int B_AUX_FAIL = 9;
    localparam int B_GND_EN = 10;
    localparam int B_GND_FAULT = 11;
    localparam int B_CHAT_OFF = 12;
    localparam int B_CHAT_UNFRZ = 13;
    localparam int B_CLK_SYNC = 14;
    localparam logic [15:0] CFG_USED_MASK = 16'h3543;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int CLK_HZ = 50_000_000;
    localparam int CHAT_TICK_MS = 100;
    localparam int CHAT_TICK_CYC = CLK_HZ / 1000 * CHAT_TICK_MS;
    localparam int COMM_TIMEOUT_MS = 100;
    localparam int COMM_TIMEOUT_CYC = CLK_HZ / 1000 * COMM_TIMEOUT_MS;
    localparam int COMM_LED_MS = 50;
    localparam int COMM_LED_CYC = CLK_HZ / 1000 * COMM_LED_MS;
    localparam logic [DATA_W-1:0] STAT_RESTRICTED = 16'h0000;

    typedef struct packed {
        logic ext_fault;
        logic int_fault;
        logic comms_ok;
        logic [CHANNELS-1:0] channel_state_leds;
    } led_drive_s;

    typedef struct packed {
        logic module_enable;
        logic fuse_sense_en;
        logic aux_sense_en;
        logic gnd_attn_en;
        logic chatter_disable;
        logic chatter_reset_on_unfreeze;
        logic chatter_tick;
    } module_ctrl_s;
endpackage : contact_input_pkg

// ---- test/contact_input_controller.sv ----
// System controller model issuing word accesses on the module I/O bus
`timescale 1ns/1ps
module contact_input_controller (
    input wire logic ref_clk,
    input wire logic [15:0] bus_rdata,
    output logic bus_sel,
    output logic bus_wr,
    output logic bus_rd,
    output logic [3:0] bus_addr,
    output logic [15:0] bus_wdata
);
    // Usual setting for this variant: fuse off, aux on, ground attention on
    localparam logic [15:0] VARIANT_CFG = 16'h0501;

    initial
    begin
        bus_sel = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 4'h0;
        bus_wdata = 16'h0000;
    end

    task automatic access(input logic [3:0] addr, input logic wr, input logic [15:0] data,
                          output logic [15:0] rdata);
        @(negedge ref_clk);
        bus_sel = 1'b1;
        bus_wr = wr;
        bus_rd = ~wr;
        bus_addr = addr;
        bus_wdata = data;
        @(posedge ref_clk);
        @(negedge ref_clk);
        rdata = bus_rdata;
        bus_sel = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        // Released lines carry inverted leftovers so a stale value never matches
        bus_addr = ~addr;
        bus_wdata = ~data;
    endtask : access

    // Raw writes exist only to show that unused bits are refused
    task automatic write_cfg(input logic [15:0] data, input logic raw);
        logic [15:0] unused_rd;
        access(contact_input_pkg::CFG_STAT_ADDR, 1'b1,
               raw ? data : (data & contact_input_pkg::CFG_USED_MASK), unused_rd);
    endtask : write_cfg

    task automatic read_word(input logic [3:0] addr, output logic [15:0] data);
        access(addr, 1'b0, 16'h0000, data);
    endtask : read_word
endmodule : contact_input_controller

// ---- test/contact_input_config_status_test.sv ----
// Self-checking bench of the contact input configuration and status register
`timescale 1ns/1ps
module contact_input_config_status_test;
    typedef struct packed {
        logic [15:0] wdata;
        logic [3:0] field;
        logic [15:0] stat;
        logic [2:0] flags;
    } row_s;
    // field = fuse,aux,gnd,sync; flags = attention,int_fault,ext_fault
    localparam row_s ROWS [0:6] = '{
        '{16'h0001, 4'h0, 16'h0001, 3'h0},
        '{16'hffff, 4'hf, 16'h7fc3, 3'h7},
        '{16'h0141, 4'ha, 16'h09c1, 3'h5},
        '{16'h0101, 4'h4, 16'h0301, 3'h6},
        '{16'h0401, 4'he, 16'h0401, 3'h0},
        '{16'h3001, 4'h1, 16'h7001, 3'h0},
        '{16'h0000, 4'hf, 16'h4000, 3'h0}};
    logic ref_clk;
    logic reset_n;
    logic bus_sel, bus_wr, bus_rd, bus_read_block, attention;
    logic [3:0] bus_addr;
    logic [15:0] bus_wdata, bus_rdata, rd, contacts;
    logic fuse, aux, gnd, sync;
    contact_input_pkg::led_drive_s leds;
    contact_input_pkg::module_ctrl_s ctrl;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int ticks;

    contact_input_config_status #(.CHAT_TICK_CYCLES(20), .COMM_TIMEOUT_CYCLES(50),
        .COMM_LED_CYCLES(5)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus_sel(bus_sel),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_read_block(bus_read_block), .fuse_blown_in(fuse),
        .aux_fail_in(aux), .gnd_fault_in(gnd), .clk_sync_in(sync),
        .contact_closed_in(contacts), .attention(attention), .leds(leds), .ctrl(ctrl));
    contact_input_controller u_ctl (.ref_clk(ref_clk), .bus_rdata(bus_rdata),
        .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            results();
        end
    end

    initial
    begin
        reset_n = 1'b0;
        {fuse, aux, gnd, sync} = 4'h0;
        contacts = 16'h0000;
        repeat (4) @(negedge ref_clk);
        reset_n = 1'b1;
        foreach (ROWS[i])
        begin
            {fuse, aux, gnd, sync} = ROWS[i].field;
            contacts = {ROWS[i].wdata[7:0], ROWS[i].wdata[15:8]};
            u_ctl.write_cfg(ROWS[i].wdata, 1'b1);
            repeat (3) @(negedge ref_clk);
            u_ctl.read_word(4'hd, rd);
            check(rd, ROWS[i].stat);
            check({attention, leds.int_fault, leds.ext_fault}, ROWS[i].flags);
            check(leds.channel_state_leds, contacts);
            check({ctrl.module_enable, ctrl.fuse_sense_en, ctrl.aux_sense_en,
                   ctrl.gnd_attn_en, ctrl.chatter_disable, ctrl.chatter_reset_on_unfreeze},
                  {ROWS[i].wdata[0], ROWS[i].wdata[6], ROWS[i].wdata[8],
                   ROWS[i].wdata[10], ROWS[i].wdata[12], ROWS[i].wdata[13]});
        end
        {fuse, aux, gnd, sync} = 4'h0;
        contacts = 16'h0000;
        // Forced error blocks other reads and lights internal fault
        u_ctl.write_cfg(16'h0003, 1'b0);
        @(negedge ref_clk);
        check({bus_read_block, leds.int_fault}, 2'b11);
        u_ctl.read_word(4'he, rd);
        check(rd, 16'h0000);
        u_ctl.write_cfg(16'h0001, 1'b0);
        @(negedge ref_clk);
        check(bus_read_block, 1'b0);
        @(negedge ref_clk);
        check(leds.comms_ok, 1'b1);
        repeat (20) @(negedge ref_clk);
        check(leds.comms_ok, 1'b0);
        // Silent controller trips the watchdog; any access clears it
        u_ctl.write_cfg(u_ctl.VARIANT_CFG, 1'b0);
        repeat (60) @(negedge ref_clk);
        check(leds.int_fault, 1'b1);
        u_ctl.read_word(4'hd, rd);
        repeat (3) @(negedge ref_clk);
        check(leds.int_fault, 1'b0);
        foreach (ROWS[i])
        begin
            if (i < 4)
            begin
                u_ctl.write_cfg(i == 0 ? 16'h0001 : i == 1 ? 16'h1001 :
                                i == 2 ? 16'h2001 : 16'h0000, 1'b0);
                repeat (2) @(negedge ref_clk);
                ticks = 0;
                repeat (100)
                begin
                    @(negedge ref_clk);
                    ticks += int'(ctrl.chatter_tick === 1'b1);
                end
                check(ticks, i == 0 ? 5 : 0);
            end
        end
        // Reset in mid-run clears the whole configuration
        u_ctl.write_cfg(16'h3543, 1'b1);
        @(negedge ref_clk);
        reset_n = 1'b0;
        @(negedge ref_clk);
        reset_n = 1'b1;
        @(negedge ref_clk);
        check({ctrl, bus_read_block, attention}, 9'h000);
        u_ctl.read_word(4'hd, rd);
        check(rd, 16'h0000);
        results();
    end
endmodule : contact_input_config_status_test
